/* pms_pkg.sv */
/*
 * Shared constants for the two-wire power-management slave command port.
 * Assumes a command-code map of byte registers reached over the two-wire bus.
 */
package pms_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Address, command codes and register layout.
    localparam logic [2:0] PMS_ADDR_UPPER = 3'h1;
    localparam int PMS_SYNC_STAGES = 2;
    localparam logic [7:0] PMS_CMD_OPERATION = 8'h01;
    localparam logic [7:0] PMS_CMD_ON_OFF_CFG = 8'h02;
    localparam logic [7:0] PMS_CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] PMS_CMD_WRITE_PROTECT = 8'h10;
    localparam logic [7:0] PMS_CMD_STORE_ALL = 8'h11;
    localparam logic [7:0] PMS_CMD_RESTORE_ALL = 8'h12;
    localparam logic [7:0] PMS_CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] PMS_CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] PMS_CMD_MFR_BASE = 8'hD0;
    localparam int PMS_MFR_COUNT = 7;
    localparam int PMS_NVM_COUNT = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions, field codes and values after reset.
    localparam int PMS_OP_ON_BIT = 7;
    localparam int PMS_OP_MARGIN_LSB = 2;
    localparam int PMS_CFG_CMD_BIT = 3;
    localparam int PMS_CFG_PIN_BIT = 2;
    localparam logic [7:0] PMS_CFG_FIXED_ONES = 8'h13;
    localparam logic [7:0] PMS_OP_RST = 8'h00;
    localparam logic [7:0] PMS_CFG_RST = 8'h17;
    localparam logic [7:0] PMS_WP_RST = 8'h00;
    localparam logic [7:0] PMS_MFR_RST = 8'h00;
    localparam logic [7:0] PMS_WP_ONLY_WP = 8'h80;
    localparam logic [7:0] PMS_WP_WP_OP = 8'h40;
    localparam logic [7:0] PMS_WP_WP_OP_CFG = 8'h20;
    localparam logic [7:0] PMS_WP_OPEN = 8'h00;
    localparam logic [3:0] PMS_MRG_LOW_IGN = 4'h5;
    localparam logic [3:0] PMS_MRG_LOW_ACT = 4'h6;
    localparam logic [3:0] PMS_MRG_HIGH_IGN = 4'h9;
    localparam logic [3:0] PMS_MRG_HIGH_ACT = 4'hA;
    localparam logic [1:0] PMS_MSEL_OFF = 2'h0;
    localparam logic [1:0] PMS_MSEL_LOW = 2'h1;
    localparam logic [1:0] PMS_MSEL_HIGH = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Event kinds passed from the bus side to the register side.
    typedef enum logic [1:0] {PMS_EV_CMD, PMS_EV_DATA, PMS_EV_SEND} pms_ev_t;

endpackage : pms_pkg

/* pms_slave.sv */
/*
 * Two-wire slave command port with on/off, margin, configuration, protection,
 * status, seven custom registers and a nonvolatile copy of them.
 * Assumes open-drain bus pins resolved outside, a free-running link clock
 * fast enough to oversample the bus, and an analog detector giving a band.
 */
// Operation
// - Answer one of 16 addresses; upper three bits 001, low four detected.
// - Address detection only starts after the bias supply leaves lockout.
// - Divider ratio band maps monotonically to addresses 0010000..0011111.
// - Write is START, address+W, command, one data byte, STOP; each acked.
// - Combined read: command, repeated START, address+R, device returns byte.
// - Command pointer survives STOP and foreign traffic for later reads.
// - Pointer never auto-increments; each access hits exactly one register.
// - Works at standard and fast-mode bus rates.
// - Unsupported commands and their data may be acked but change nothing except the communication-fault flag and alert.
// - Unsupported command sets communication-fault flag and pulls alert low.
// - On/off register bit 7 turns converter on; bits 6, 1, 0 ignored.
// - Bits 5:2 select margin off, low or high, ignoring or acting faults.
// - On/off bit acts only when configuration command-control bit is set.
// - Seven custom registers 0 to 6 are provided.
// - Store copies user registers into nonvolatile cells.
// - Restore copies nonvolatile cells back, overwriting user registers.
// - Clear-faults clears every latched status flag.
// - Status word is read-only; a write only sets its communication-fault bit.
// - Write-protect register governs which commands may be written.
`timescale 1ns/100ps
module pms_slave
    import pms_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_link_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic bias_ok_i,
    input wire logic addr_done_i,
    input wire logic [3:0] addr_band_i,
    input wire logic en_pin_i,
    input wire logic ov_fault_i,
    input wire logic oc_fault_i,
    output logic [6:0] addr_o,
    output logic addr_valid_o,
    output logic conv_en_o,
    output logic [1:0] margin_sel_o,
    output logic margin_fault_act_o,
    output logic alert_o,
    output logic alert_oe_o,
    output logic [7:0] custom_reg_o,
    output logic [7:0] delay_ctrl_o,
    output logic [7:0] mode_soft_start_o,
    output logic [7:0] freq_cfg_o,
    output logic [7:0] output_trim_register_o,
    output logic [7:0] output_margin_levels_register_o,
    output logic [7:0] turn_on_supply_level_register_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Command decoding helpers.
    function automatic logic is_mfr(input logic [7:0] c);
        is_mfr = (c >= PMS_CMD_MFR_BASE) && (c < PMS_CMD_MFR_BASE + 8'(PMS_MFR_COUNT));
    endfunction : is_mfr

    function automatic logic is_supported(input logic [7:0] c);
        is_supported = is_mfr(c) || c == PMS_CMD_OPERATION || c == PMS_CMD_ON_OFF_CFG
            || c == PMS_CMD_CLEAR_FAULTS || c == PMS_CMD_WRITE_PROTECT
            || c == PMS_CMD_STORE_ALL || c == PMS_CMD_RESTORE_ALL
            || c == PMS_CMD_STATUS_BYTE || c == PMS_CMD_STATUS_WORD;
    endfunction : is_supported

    function automatic logic wp_allows(input logic [7:0] wp, input logic [7:0] c);
        logic rw;
        rw = is_mfr(c) || c == PMS_CMD_OPERATION || c == PMS_CMD_ON_OFF_CFG
            || c == PMS_CMD_WRITE_PROTECT;
        case (wp)
            PMS_WP_ONLY_WP: wp_allows = c == PMS_CMD_WRITE_PROTECT;
            PMS_WP_WP_OP: wp_allows = c == PMS_CMD_WRITE_PROTECT || c == PMS_CMD_OPERATION;
            PMS_WP_WP_OP_CFG: wp_allows = rw && !is_mfr(c);
            default: wp_allows = rw;
        endcase
    endfunction : wp_allows

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: reset and pin synchronisers, bus protocol engine.
    typedef enum {LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WR, LS_WR_ACK, LS_RD, LS_RD_ACK} pms_ls_t;
    pms_ls_t lst_r;
    logic rst_lm_r, rst_l_r;
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic ok_m_r, ok_s_r, rdt_m_r, rdt_s_r, rdt_d_r, rd_ack_tgl_r;
    logic [7:0] shreg_r, tx_r, ev_byte_r;
    logic [2:0] cnt_r;
    logic full_r, rnw_r, got_cmd_r, got_data_r, rd_hi_r, ev_tgl_r;
    logic [15:0] rd_word_l_r;
    logic rd_tgl_r;
    logic [15:0] rd_hold_r;
    pms_ev_t ev_kind_r;
    logic [3:0] addr_lo_r;

    // oversampling. The link clock samples both pins far above fast-mode rate.
    always_ff @(posedge clk_link_i) begin
        rst_lm_r <= rst_i;
        rst_l_r <= rst_lm_r;
        {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
        {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
        {ok_m_r, ok_s_r} <= {addr_valid_o, ok_m_r};
        {rdt_m_r, rdt_s_r, rdt_d_r} <= {rd_tgl_r, rdt_m_r, rdt_s_r};
    end

    wire logic scl_rise = scl_s_r && !scl_d_r;
    wire logic scl_fall = !scl_s_r && scl_d_r;
    wire logic bus_start = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    wire logic bus_stop = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
    // address compare. Only the latched detector result is matched.
    wire logic addr_hit = ok_s_r && shreg_r[7:1] == {PMS_ADDR_UPPER, addr_lo_r};
    wire logic rd_new = rdt_s_r ^ rdt_d_r;

    always_ff @(posedge clk_link_i) begin
        if (rst_l_r) begin
            rd_word_l_r <= 16'h0000;
            rd_ack_tgl_r <= 1'b0;
        end else if (rd_new) begin
            rd_word_l_r <= rd_hold_r;
            rd_ack_tgl_r <= rdt_s_r;
        end
    end

    always_ff @(posedge clk_link_i) begin
        if (rst_l_r) begin
            lst_r <= LS_IDLE;
            {shreg_r, tx_r, ev_byte_r} <= 24'h000000;
            {cnt_r, full_r, rnw_r, got_cmd_r, got_data_r, rd_hi_r} <= 8'h00;
            {ev_tgl_r, sda_o, sda_oe_o} <= 3'h0;
            ev_kind_r <= PMS_EV_CMD;
        end else if (bus_start) begin
            lst_r <= LS_ADDR;
            {cnt_r, full_r, sda_oe_o} <= 5'h00;
        end else if (bus_stop) begin
            lst_r <= LS_IDLE;
            sda_oe_o <= 1'b0;
            // send byte. A lone command byte followed by stop executes.
            if (got_cmd_r && !got_data_r && !rnw_r && lst_r == LS_WR) begin
                ev_kind_r <= PMS_EV_SEND;
                ev_tgl_r <= !ev_tgl_r;
            end
        end else begin
            case (lst_r)
                LS_ADDR, LS_WR: begin
                    if (scl_rise && !full_r) begin
                        shreg_r <= {shreg_r[6:0], sda_s_r};
                        cnt_r <= 3'(cnt_r + 3'h1);
                        full_r <= cnt_r == 3'h7;
                    end else if (scl_fall && full_r) begin
                        full_r <= 1'b0;
                        if (lst_r == LS_ADDR) begin
                            // foreign address. No acknowledge, line left released.
                            lst_r <= addr_hit ? LS_ADDR_ACK : LS_IDLE;
                            sda_oe_o <= addr_hit;
                            rnw_r <= shreg_r[0];
                            if (addr_hit && !shreg_r[0]) begin
                                {got_cmd_r, got_data_r} <= 2'h0;
                            end
                        end else begin
                            // byte acknowledge. First byte is the command.
                            lst_r <= LS_WR_ACK;
                            sda_oe_o <= 1'b1;
                            ev_kind_r <= got_cmd_r ? PMS_EV_DATA : PMS_EV_CMD;
                            ev_byte_r <= shreg_r;
                            ev_tgl_r <= !ev_tgl_r;
                            got_cmd_r <= 1'b1;
                            got_data_r <= got_cmd_r;
                        end
                    end
                end
                LS_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 3'h0;
                        // read data. The addressed byte follows the acknowledge.
                        lst_r <= rnw_r ? LS_RD : LS_WR;
                        tx_r <= rd_word_l_r[7:0];
                        sda_oe_o <= rnw_r && !rd_word_l_r[7];
                        rd_hi_r <= 1'b0;
                    end
                end
                LS_WR_ACK: begin
                    if (scl_fall) begin
                        lst_r <= LS_WR;
                        sda_oe_o <= 1'b0;
                    end
                end
                LS_RD: begin
                    if (scl_fall && cnt_r == 3'h7) begin
                        lst_r <= LS_RD_ACK;
                        sda_oe_o <= 1'b0;
                    end else if (scl_fall) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        sda_oe_o <= !tx_r[6];
                        cnt_r <= 3'(cnt_r + 3'h1);
                    end
                end
                LS_RD_ACK: begin
                    if (scl_rise) begin
                        lst_r <= sda_s_r ? LS_IDLE : LS_RD_ACK;
                        full_r <= !sda_s_r;
                    end else if (scl_fall && full_r) begin
                        full_r <= 1'b0;
                        lst_r <= LS_RD;
                        cnt_r <= 3'h0;
                        tx_r <= rd_hi_r ? 8'h00 : rd_word_l_r[15:8];
                        sda_oe_o <= rd_hi_r || !rd_word_l_r[15];
                        rd_hi_r <= 1'b1;
                    end
                end
                default: lst_r <= LS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers, event receive and read-back handshake.
    logic [4:0] in_m_r, in_s_r;
    logic evt_m_r, evt_s_r, evt_d_r, ack_m_r, ack_s_r;
    logic [3:0] band_m_r, band_s_r;
    logic [7:0] op_r, cfg_r, wp_r, ptr_r;
    logic [7:0] mfr_r [0:PMS_MFR_COUNT-1];
    logic [7:0] nvm_r [0:PMS_NVM_COUNT-1];
    logic dcnt_r, ov_r, oc_r, cml_r;

    always_ff @(posedge clk_sys_i) begin
        in_m_r <= {bias_ok_i, addr_done_i, en_pin_i, ov_fault_i, oc_fault_i};
        in_s_r <= in_m_r;
        band_m_r <= addr_band_i;
        band_s_r <= band_m_r;
        {evt_m_r, evt_s_r, evt_d_r} <= {ev_tgl_r, evt_m_r, evt_s_r};
        {ack_m_r, ack_s_r} <= {rd_ack_tgl_r, ack_m_r};
    end

    wire logic bias_s = in_s_r[4];
    wire logic done_s = in_s_r[3];
    wire logic en_s = in_s_r[2];
    wire logic ev_stb = evt_s_r ^ evt_d_r;
    wire logic ev_cmd = ev_stb && ev_kind_r == PMS_EV_CMD;
    wire logic ev_data = ev_stb && ev_kind_r == PMS_EV_DATA;
    wire logic ev_send = ev_stb && ev_kind_r == PMS_EV_SEND;
    wire logic [2:0] mfr_idx = 3'(ptr_r - PMS_CMD_MFR_BASE);
    wire logic wp_bad = ptr_r == PMS_CMD_WRITE_PROTECT && ev_byte_r != PMS_WP_ONLY_WP
        && ev_byte_r != PMS_WP_WP_OP && ev_byte_r != PMS_WP_WP_OP_CFG && ev_byte_r != PMS_WP_OPEN;
    // write protection. status and other codes are never writable.
    wire logic wr_ok = ev_data && !dcnt_r && wp_allows(wp_r, ptr_r) && !wp_bad;
    wire logic do_clear = ev_send && ptr_r == PMS_CMD_CLEAR_FAULTS;
    wire logic do_store = ev_send && ptr_r == PMS_CMD_STORE_ALL;
    wire logic do_restore = ev_send && ptr_r == PMS_CMD_RESTORE_ALL;
    // communication fault. Unsupported codes or refused data raise it.
    wire logic cml_set = (ev_cmd && !is_supported(ev_byte_r)) || (ev_data && !wr_ok);
    wire logic [7:0] status_lo = {1'b0, !conv_en_o, ov_r, oc_r, 2'h0, cml_r, 1'b0};
    wire logic [7:0] rd_byte = ptr_r == PMS_CMD_OPERATION ? op_r
        : ptr_r == PMS_CMD_ON_OFF_CFG ? cfg_r
        : ptr_r == PMS_CMD_WRITE_PROTECT ? wp_r
        : (ptr_r == PMS_CMD_STATUS_BYTE || ptr_r == PMS_CMD_STATUS_WORD) ? status_lo
        : is_mfr(ptr_r) ? mfr_r[mfr_idx] : 8'h00;
    wire logic [3:0] mrg = op_r[PMS_OP_MARGIN_LSB +: 4];
    // margin decode. Undefined codes leave margining off.
    wire logic [1:0] msel_nxt = (mrg == PMS_MRG_LOW_IGN || mrg == PMS_MRG_LOW_ACT) ? PMS_MSEL_LOW
        : (mrg == PMS_MRG_HIGH_IGN || mrg == PMS_MRG_HIGH_ACT) ? PMS_MSEL_HIGH : PMS_MSEL_OFF;
    // on/off bit. it only counts when command control is enabled.
    wire logic conv_en_nxt = addr_valid_o && (!cfg_r[PMS_CFG_CMD_BIT] || op_r[PMS_OP_ON_BIT])
        && (!cfg_r[PMS_CFG_PIN_BIT] || en_s);

    // read-back. A fresh word is handed over after each acknowledge.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rd_tgl_r <= 1'b0;
            rd_hold_r <= 16'h0000;
        end else if (ack_s_r == rd_tgl_r) begin
            rd_tgl_r <= !rd_tgl_r;
            rd_hold_r <= {8'h00, rd_byte};
        end
    end

    // address latch. band maps to the low address bits, held.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !bias_s) begin
            addr_valid_o <= 1'b0;
            addr_lo_r <= 4'h0;
        end else if (done_s && !addr_valid_o) begin
            addr_valid_o <= 1'b1;
            addr_lo_r <= band_s_r;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {op_r, wp_r, ptr_r} <= {PMS_OP_RST, PMS_WP_RST, 8'h00};
            cfg_r <= PMS_CFG_RST;
            {dcnt_r, ov_r, oc_r, cml_r, conv_en_o, margin_fault_act_o} <= 6'h00;
            {alert_o, alert_oe_o, margin_sel_o} <= 4'h0;
            for (int i = 0; i < PMS_MFR_COUNT; i++) mfr_r[i] <= PMS_MFR_RST;
            nvm_r[0] <= PMS_CFG_RST;
            for (int i = 1; i < PMS_NVM_COUNT; i++) nvm_r[i] <= PMS_MFR_RST;
        end else begin
            conv_en_o <= conv_en_nxt;
            margin_sel_o <= msel_nxt;
            margin_fault_act_o <= msel_nxt != PMS_MSEL_OFF && mrg[1];
            // pointer kept across stop. data bytes never move it.
            if (ev_cmd) ptr_r <= ev_byte_r;
            dcnt_r <= ev_cmd ? 1'b0 : (dcnt_r || ev_data);
            // ignored data. Only an allowed first data byte writes.
            if (wr_ok && ptr_r == PMS_CMD_OPERATION) op_r <= ev_byte_r;
            if (wr_ok && ptr_r == PMS_CMD_ON_OFF_CFG) cfg_r <= ev_byte_r | PMS_CFG_FIXED_ONES;
            if (wr_ok && ptr_r == PMS_CMD_WRITE_PROTECT) wp_r <= ev_byte_r;
            if (wr_ok && is_mfr(ptr_r)) mfr_r[mfr_idx] <= ev_byte_r;
            if (do_store) begin
                nvm_r[0] <= cfg_r;
                for (int i = 1; i < PMS_NVM_COUNT; i++) nvm_r[i] <= mfr_r[i-1];
            end
            if (do_restore) begin
                cfg_r <= nvm_r[0] | PMS_CFG_FIXED_ONES;
                for (int i = 0; i < PMS_MFR_COUNT; i++) mfr_r[i] <= nvm_r[i+1];
            end
            // clear faults. A fault present in the same cycle still sets.
            ov_r <= (ov_r && !do_clear) || in_s_r[1];
            oc_r <= (oc_r && !do_clear) || in_s_r[0];
            cml_r <= (cml_r && !do_clear) || cml_set;
            alert_oe_o <= ((ov_r || oc_r || cml_r) && !do_clear) || in_s_r[1] || in_s_r[0]
                || cml_set;
        end
    end

    assign addr_o = {PMS_ADDR_UPPER, addr_lo_r};
    assign custom_reg_o = mfr_r[0];
    assign delay_ctrl_o = mfr_r[1];
    assign mode_soft_start_o = mfr_r[2];
    assign freq_cfg_o = mfr_r[3];
    assign output_trim_register_o = mfr_r[4];
    assign output_margin_levels_register_o = mfr_r[5];
    assign turn_on_supply_level_register_o = mfr_r[6];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_addr_upper: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        addr_valid_o |-> addr_o[6:4] == PMS_ADDR_UPPER) else $error("address upper bits wrong");
    chk_addr_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        addr_valid_o && $past(addr_valid_o) |-> $stable(addr_o)) else $error("address moved");
    chk_no_addr_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !bias_s |=> !addr_valid_o) else $error("address valid in lockout");
    chk_cmd_onoff: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        addr_valid_o && cfg_r[PMS_CFG_CMD_BIT] && !cfg_r[PMS_CFG_PIN_BIT]
        |=> conv_en_o == $past(op_r[PMS_OP_ON_BIT])) else $error("on/off bit not obeyed");
    chk_margin_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mrg == PMS_MRG_HIGH_ACT |=> margin_sel_o == PMS_MSEL_HIGH && margin_fault_act_o)
        else $error("margin high decode wrong");
    chk_clear_all: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_clear && !in_s_r[1] && !in_s_r[0] |=> !ov_r && !oc_r && !cml_r)
        else $error("flags not cleared");
    chk_unsup_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ev_cmd && !is_supported(ev_byte_r) |=> cml_r && alert_oe_o) else $error("no fault flag");
    chk_wp_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ev_data && wp_r == PMS_WP_ONLY_WP && ptr_r == PMS_CMD_OPERATION |=> $stable(op_r))
        else $error("protected write took effect");
    chk_store_copy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_store |=> nvm_r[0] == $past(cfg_r) && nvm_r[5] == $past(mfr_r[4]))
        else $error("store did not copy");
    chk_foreign_addr: assert property (@(posedge clk_link_i) disable iff (rst_l_r)
        lst_r == LS_ADDR && scl_fall && full_r && !addr_hit && !bus_start && !bus_stop
        |=> lst_r == LS_IDLE && !sda_oe_o) else $error("foreign address acked");
    chk_byte_ack: assert property (@(posedge clk_link_i) disable iff (rst_l_r)
        lst_r == LS_WR && scl_fall && full_r && !bus_start && !bus_stop |=> sda_oe_o)
        else $error("written byte not acked");
    cov_write: cover property (@(posedge clk_sys_i) disable iff (rst_i) wr_ok);
    cov_send: cover property (@(posedge clk_sys_i) disable iff (rst_i) ev_send);
    cov_read: cover property (@(posedge clk_link_i) disable iff (rst_l_r) lst_r == LS_RD_ACK);

endmodule : pms_slave

/* pms_host_model.sv */
/*
 * Bus master model driving the clock and data lines of the two-wire bus.
 * Assumes the bench resolves the pulled-up data line from all drivers.
 */
`timescale 1ns/100ps
module pms_host_model (
    output logic scl_o,
    output logic sda_drv_o,
    input wire logic sda_i
);
    int hp = 1250;
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // start or repeated start.
    task automatic start;
        sda_drv_o = 1'b1;
        #(hp);
        scl_o = 1'b1;
        #(hp);
        sda_drv_o = 1'b0;
        #(hp);
        scl_o = 1'b0;
        #(hp / 4);
    endtask : start
    task automatic stop;
        sda_drv_o = 1'b0;
        #(hp);
        scl_o = 1'b1;
        #(hp);
        sda_drv_o = 1'b1;
        #(hp);
    endtask : stop
    // One bit at the fast-mode rate.
    task automatic bitx(input logic b, output logic r);
        sda_drv_o = b;
        #(hp);
        scl_o = 1'b1;
        #(hp);
        r = sda_i;
        scl_o = 1'b0;
        #(hp / 4);
    endtask : bitx
    // One byte out and in, then the acknowledge bit.
    task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(m, ack);
        ack = ~ack;
    endtask : xbyte
endmodule : pms_host_model

/* pmbus_slave_command_port_tb.sv */
/*
 * Self-checking bench for the two-wire slave command port.
 * Assumes the package and the bus master model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module pmbus_slave_command_port_tb
    import pms_pkg::*;
;
    localparam logic [6:0] ADR = {PMS_ADDR_UPPER, 4'hA};
    logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_i = 1'b1, bias_ok_i = 1'b0;
    logic addr_done_i = 1'b1, en_pin_i = 1'b0, ov_fault_i = 1'b0, oc_fault_i = 1'b0;
    logic [3:0] addr_band_i = 4'hA;
    logic scl, sda_drv, sda_o, sda_oe_o, addr_valid_o, conv_en_o;
    logic margin_fault_act_o, alert_oe_o, a;
    logic [1:0] margin_sel_o;
    logic [6:0] addr_o;
    logic [7:0] output_trim_register_o, q;
    logic [3:0] mc [5] = '{4'h5, 4'h6, 4'h9, 4'hA, 4'h1};
    logic [1:0] ms [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic mf [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int n_errors = 0, n_checks = 0;
    wire sda = sda_drv & ~(sda_oe_o & ~sda_o);
    initial forever #10 clk_sys_i = ~clk_sys_i;
    initial begin
        #1.7;
        forever #3 clk_link_i = ~clk_link_i;
    end
    pms_host_model pms_host_model_inst (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda));
    pms_slave pms_slave_inst (.clk_sys_i, .rst_i, .clk_link_i, .scl_i(scl), .sda_i(sda), .sda_o,
        .sda_oe_o, .bias_ok_i, .addr_done_i, .addr_band_i, .en_pin_i, .ov_fault_i, .oc_fault_i,
        .addr_o, .addr_valid_o, .conv_en_o, .margin_sel_o, .margin_fault_act_o, .alert_o(),
        .alert_oe_o, .custom_reg_o(), .delay_ctrl_o(), .mode_soft_start_o(), .freq_cfg_o(),
        .output_trim_register_o, .output_margin_levels_register_o(),
        .turn_on_supply_level_register_o());
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic addr_byte(input logic r);
        pms_host_model_inst.xbyte({ADR, r}, 1'b1, q, a);
        `CHK(a, 1'b1)
    endtask : addr_byte
    task automatic foreign;
        pms_host_model_inst.start();
        pms_host_model_inst.xbyte({7'h1B, 1'b0}, 1'b1, q, a);
        `CHK(a, 1'b0)
        pms_host_model_inst.stop();
    endtask : foreign
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit one);
        pms_host_model_inst.start();
        addr_byte(1'b0);
        pms_host_model_inst.xbyte(c, 1'b1, q, a);
        `CHK(a, 1'b1)
        if (one) begin
            pms_host_model_inst.xbyte(d, 1'b1, q, a);
            `CHK(a, 1'b1)
        end
        pms_host_model_inst.stop();
    endtask : wr
    task automatic rd(input logic [7:0] c, input bit sep, input logic [7:0] e);
        if (sep) begin
            wr(c, 8'h00, 1'b0);
            foreign();
        end else begin
            pms_host_model_inst.start();
            addr_byte(1'b0);
            pms_host_model_inst.xbyte(c, 1'b1, q, a);
        end
        pms_host_model_inst.start();
        addr_byte(1'b1);
        pms_host_model_inst.xbyte(8'hFF, 1'b1, q, a);
        `CHK(q, e)
        pms_host_model_inst.stop();
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #2 rst_i = 1'b0;
        repeat (30) @(posedge clk_sys_i);
        `CHK(addr_o, 7'h10)
        `CHK(addr_valid_o, 1'b0)
        #2 bias_ok_i = 1'b1;
        for (int k = 0; addr_valid_o !== 1'b1; k++) begin
            if (k == 50) begin
                n_errors++;
                conclude();
            end
            @(posedge clk_sys_i);
        end
        `CHK(addr_o, 7'h1A)
        #2 addr_done_i = 1'b0;
        addr_band_i = 4'h0;
        repeat (20) @(posedge clk_sys_i);
        `CHK(addr_o, 7'h1A)
        foreign();
        wr(PMS_CMD_OPERATION, 8'h80, 1'b1);
        `CHK(conv_en_o, 1'b0)
        wr(PMS_CMD_ON_OFF_CFG, 8'h08, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wr(PMS_CMD_OPERATION, 8'hC3 | {2'b00, mc[i], 2'b00}, 1'b1);
            `CHK(margin_sel_o, ms[i])
            `CHK(margin_fault_act_o, mf[i])
            `CHK(conv_en_o, 1'b1)
        end
        rd(PMS_CMD_ON_OFF_CFG, 1'b0, 8'h1B);
        rd(PMS_CMD_ON_OFF_CFG, 1'b1, 8'h1B);
        wr(8'h55, 8'h33, 1'b1);
        `CHK(alert_oe_o, 1'b1)
        `CHK(conv_en_o, 1'b1)
        wr(PMS_CMD_STATUS_WORD, 8'hFF, 1'b1);
        rd(PMS_CMD_STATUS_BYTE, 1'b0, 8'h02);
        wr(PMS_CMD_CLEAR_FAULTS, 8'h00, 1'b0);
        `CHK(alert_oe_o, 1'b0)
        wr(8'hD4, 8'h5A, 1'b1);
        `CHK(output_trim_register_o, 8'h5A)
        wr(PMS_CMD_STORE_ALL, 8'h00, 1'b0);
        wr(8'hD4, 8'h00, 1'b1);
        wr(PMS_CMD_RESTORE_ALL, 8'h00, 1'b0);
        `CHK(output_trim_register_o, 8'h5A)
        wr(PMS_CMD_WRITE_PROTECT, 8'h80, 1'b1);
        wr(PMS_CMD_OPERATION, 8'h00, 1'b1);
        `CHK(conv_en_o, 1'b1)
        conclude();
    end
endmodule : pmbus_slave_command_port_tb
